// file: ecc_bus_if.sv
// byte-wide register port joining the host bridge and the counter device
`timescale 1ns/10ps
interface ecc_bus_if;
    logic [3:0] addr;
    logic [7:0] wdata;
    logic       wr_stb;
    logic       rd_stb;
    logic [7:0] rdata;
    logic       rd_ack;

    modport device (
        input  addr,
        input  wdata,
        input  wr_stb,
        input  rd_stb,
        output rdata,
        output rd_ack
    );
    modport host (
        output addr,
        output wdata,
        output wr_stb,
        output rd_stb,
        input  rdata,
        input  rd_ack
    );
endinterface

// file: ecc_device.sv
// elapsed counter: control registers, periodic flag, square wave and interrupt
//
// Design decision made here: the byte-wide register port; the APB slave port is in ecc_host.
`timescale 1ns/10ps
module ecc_device #(
    parameter int COUNT_W = ecc_pkg::COUNT_W
) (
    input  wire logic  core_clk,
    input  wire logic  reset,
    ecc_bus_if.device  bus,
    input  wire logic  osc_level,
    input  wire logic  event_gate_input,
    input  wire logic  on_battery,
    input  wire logic  power_fail,
    input  wire logic  alarm_match_set,
    output logic       osc_enable,
    output logic       counting,
    output logic       irq_n_o,
    output logic       irq_n_oe,
    output logic       square_wave_pin_o,
    output logic       square_wave_pin_oe
);
    // ------------------------------------------------------------
    // functions
    // ------------------------------------------------------------
    // low counter bits that must be zero for each periodic rate code
    function automatic logic [5:0] periodic_span(input logic [3:0] code);
        case (code)
            4'h1:    periodic_span = 6'h00;
            4'h2:    periodic_span = 6'h01;
            4'h3:    periodic_span = 6'h02;
            4'h4:    periodic_span = 6'h03;
            4'h5:    periodic_span = 6'h04;
            4'h6:    periodic_span = 6'h05;
            4'h7:    periodic_span = 6'h09;
            4'h8:    periodic_span = 6'h0a;
            4'h9:    periodic_span = 6'h0b;
            4'ha:    periodic_span = 6'h0c;
            4'hb:    periodic_span = 6'h12;
            4'hc:    periodic_span = 6'h18;
            4'hd:    periodic_span = 6'h1c;
            4'he:    periodic_span = 6'h1f;
            default: periodic_span = 6'h21;
        endcase
    endfunction

    function automatic logic counter_byte(input logic [3:0] a);
        counter_byte = (a <= ecc_pkg::ADDR_SEC3);
    endfunction

    // ------------------------------------------------------------
    // registers
    // ------------------------------------------------------------
    logic [7:0]         ctrl_a_q;
    logic [7:0]         ctrl_b_q;
    logic               periodic_flag_q;
    logic               alarm_match_flag_q;
    logic               square_prescaler_hold_q;
    logic [COUNT_W-1:0] count_q;
    logic [COUNT_W-1:0] user_copy_q;
    logic               user_dirty_q;
    logic               osc_prev_q;
    logic [ecc_pkg::TICK_DIV_W-1:0] tick_div_q;
    logic [ecc_pkg::SQ_PRESC_W-1:0] sq_presc_q;
    logic [7:0]         rdata_q;
    logic               rd_ack_q;
    logic               square_q;

    logic               shadow_refresh_allow;
    logic               osc_run_bit;
    logic [1:0]         count_source;
    logic               event_level_polarity;
    logic               square_output_on;
    logic               periodic_irq_mask;
    logic               alarm_irq_mask;
    logic [3:0]         periodic_rate_field;
    logic [3:0]         square_rate_field;

    assign shadow_refresh_allow = ctrl_a_q[ecc_pkg::CA_SHADOW_REFRESH_ALLOW];
    assign osc_run_bit          = ctrl_a_q[ecc_pkg::CA_OSC_RUN_BIT];
    assign count_source         = {ctrl_a_q[ecc_pkg::CA_COUNT_SOURCE_HI],
                                   ctrl_a_q[ecc_pkg::CA_COUNT_SOURCE_LO]};
    assign event_level_polarity = ctrl_a_q[ecc_pkg::CA_EVENT_LEVEL_POLARITY];
    assign square_output_on     = ctrl_a_q[ecc_pkg::CA_SQUARE_OUTPUT_ON];
    assign periodic_irq_mask    = ctrl_a_q[ecc_pkg::CA_PERIODIC_IRQ_MASK];
    assign alarm_irq_mask       = ctrl_a_q[ecc_pkg::CA_ALARM_IRQ_MASK];
    assign periodic_rate_field  = ctrl_b_q[ecc_pkg::CB_PERIODIC_RATE_LSB +: 4];
    assign square_rate_field    = ctrl_b_q[ecc_pkg::CB_SQUARE_RATE_LSB +: 4];

    logic wr_ctrl_a;
    logic wr_ctrl_b;
    logic wr_status;
    logic wr_count;
    logic te_rise;
    assign wr_ctrl_a = bus.wr_stb && (bus.addr == ecc_pkg::ADDR_CTRL_A);
    assign wr_ctrl_b = bus.wr_stb && (bus.addr == ecc_pkg::ADDR_CTRL_B);
    assign wr_status = bus.wr_stb && (bus.addr == ecc_pkg::ADDR_STATUS);
    assign wr_count  = bus.wr_stb && counter_byte(bus.addr);
    assign te_rise   = wr_ctrl_a && !shadow_refresh_allow
                       && bus.wdata[ecc_pkg::CA_SHADOW_REFRESH_ALLOW];

    always_ff @(posedge core_clk or posedge reset) begin
        if (reset) begin
            ctrl_a_q <= ecc_pkg::CTRL_A_RESET;
            ctrl_b_q <= ecc_pkg::CTRL_B_RESET;
        end else begin
            if (wr_ctrl_a) begin
                ctrl_a_q <= bus.wdata;
            end
            if (wr_ctrl_b) begin
                ctrl_b_q <= bus.wdata;
            end
        end
    end

    // ------------------------------------------------------------
    // oscillator and 4096 hz tick
    // ------------------------------------------------------------
    // the crystal model is outside; this output gates it
    assign osc_enable = osc_run_bit;

    logic osc_rise;
    logic tick;
    assign osc_rise = osc_run_bit && osc_level && !osc_prev_q;
    assign tick     = osc_rise && (&tick_div_q);

    always_ff @(posedge core_clk or posedge reset) begin
        if (reset) begin
            osc_prev_q <= 1'b0;
            tick_div_q <= '0;
        end else begin
            osc_prev_q <= osc_level;
            if (osc_rise) begin
                tick_div_q <= tick_div_q + 1'b1;
            end
        end
    end

    // ------------------------------------------------------------
    // count source and up counter
    // ------------------------------------------------------------
    logic event_active;
    always_comb begin
        event_active = (event_gate_input == event_level_polarity);
        case (count_source)
            ecc_pkg::SRC_ALWAYS:  counting = 1'b1;
            ecc_pkg::SRC_EVENT:   counting = event_active && !power_fail;
            ecc_pkg::SRC_MAIN:    counting = !on_battery;
            ecc_pkg::SRC_BATTERY: counting = on_battery;
            default:              counting = 1'b0;
        endcase
    end

    logic [COUNT_W-1:0] count_next;
    assign count_next = count_q + 1'b1;

    // a user load lands when the gate goes high again after writes
    always_ff @(posedge core_clk or posedge reset) begin
        if (reset) begin
            count_q <= '0;
        end else if (te_rise && user_dirty_q) begin
            count_q <= user_copy_q;
        end else if (tick && counting) begin
            count_q <= count_next;
        end
    end

    // ------------------------------------------------------------
    // user readable copy
    // ------------------------------------------------------------
    always_ff @(posedge core_clk or posedge reset) begin
        if (reset) begin
            user_copy_q  <= '0;
            user_dirty_q <= 1'b0;
        end else if (wr_count) begin
            user_dirty_q <= 1'b1;
            case (bus.addr)
                ecc_pkg::ADDR_SUBSEC0:
                    user_copy_q[3:0] <= bus.wdata[ecc_pkg::SS0_FRAC_LSB +: 4];
                ecc_pkg::ADDR_SUBSEC1:
                    user_copy_q[11:4] <= bus.wdata;
                default:
                    user_copy_q[8*(bus.addr-ecc_pkg::ADDR_SEC0)+ecc_pkg::SUBSEC_W +: 8]
                        <= bus.wdata;
            endcase
        end else if (tick && shadow_refresh_allow) begin
            user_copy_q  <= count_q;
            user_dirty_q <= 1'b0;
        end
    end

    // ------------------------------------------------------------
    // periodic and alarm flags
    // ------------------------------------------------------------
    logic [COUNT_W-1:0] span_mask;
    logic               periodic_hit;
    assign span_mask    = ({{(COUNT_W-1){1'b0}}, 1'b1} << periodic_span(periodic_rate_field))
                          - 1'b1;
    // counter keeps running whatever the flag does
    assign periodic_hit = tick && counting && (periodic_rate_field != 4'h0)
                          && ((count_next & span_mask) == '0);

    // set wins over a same-cycle status write
    always_ff @(posedge core_clk or posedge reset) begin
        if (reset) begin
            periodic_flag_q    <= 1'b0;
            alarm_match_flag_q <= 1'b0;
        end else begin
            if (periodic_hit) begin
                periodic_flag_q <= 1'b1;
            end else if (wr_status) begin
                periodic_flag_q <= 1'b0;
            end
            if (alarm_match_set) begin
                alarm_match_flag_q <= 1'b1;
            end else if (wr_status) begin
                alarm_match_flag_q <= 1'b0;
            end
        end
    end

    // no supply input gates the interrupt output; of the interrupt sources, supply inputs reach only the periodic flag, through the count source
    assign irq_n_o  = 1'b0;
    assign irq_n_oe = (periodic_flag_q && periodic_irq_mask)
                      || (alarm_match_flag_q && alarm_irq_mask);

    // ------------------------------------------------------------
    // square wave
    // ------------------------------------------------------------
    always_ff @(posedge core_clk or posedge reset) begin
        if (reset) begin
            square_prescaler_hold_q <= 1'b0;
        end else if (bus.wr_stb && (bus.addr == ecc_pkg::ADDR_SUBSEC0)) begin
            square_prescaler_hold_q <= bus.wdata[ecc_pkg::SS0_SQUARE_HOLD_BIT];
        end
    end

    // separate from the counter; of the counter writes only a subseconds0 write reaches it, through the hold bit
    always_ff @(posedge core_clk or posedge reset) begin
        if (reset) begin
            sq_presc_q <= '0;
        end else begin
            if (osc_rise) begin
                sq_presc_q[ecc_pkg::SQ_FREE_BITS-1:0] <=
                    sq_presc_q[ecc_pkg::SQ_FREE_BITS-1:0] + 1'b1;
            end
            if (square_prescaler_hold_q) begin
                sq_presc_q[ecc_pkg::SQ_PRESC_W-1:ecc_pkg::SQ_FREE_BITS] <= '0;
            end else if (osc_rise && (&sq_presc_q[ecc_pkg::SQ_FREE_BITS-1:0])) begin
                sq_presc_q[ecc_pkg::SQ_PRESC_W-1:ecc_pkg::SQ_FREE_BITS] <=
                    sq_presc_q[ecc_pkg::SQ_PRESC_W-1:ecc_pkg::SQ_FREE_BITS] + 1'b1;
            end
        end
    end

    // code 0 passes the oscillator level through, registered on core_clk
    always_ff @(posedge core_clk or posedge reset) begin
        if (reset) begin
            square_q <= 1'b0;
        end else if (!square_output_on || !osc_run_bit) begin
            square_q <= 1'b0;
        end else if (square_rate_field == 4'h0) begin
            square_q <= osc_level;
        end else begin
            square_q <= sq_presc_q[square_rate_field];
        end
    end

    assign square_wave_pin_o  = square_q;
    assign square_wave_pin_oe = !power_fail;

    // ------------------------------------------------------------
    // read port
    // ------------------------------------------------------------
    always_ff @(posedge core_clk or posedge reset) begin
        if (reset) begin
            rdata_q  <= 8'h00;
            rd_ack_q <= 1'b0;
        end else begin
            rd_ack_q <= bus.rd_stb;
            if (bus.rd_stb) begin
                case (bus.addr)
                    ecc_pkg::ADDR_SUBSEC0: rdata_q <= {user_copy_q[3:0], 3'h0,
                                                       square_prescaler_hold_q};
                    ecc_pkg::ADDR_SUBSEC1: rdata_q <= user_copy_q[11:4];
                    ecc_pkg::ADDR_CTRL_A:  rdata_q <= ctrl_a_q;
                    ecc_pkg::ADDR_CTRL_B:  rdata_q <= ctrl_b_q;
                    ecc_pkg::ADDR_STATUS:  rdata_q <= {1'b0, tick, 4'h0,
                                                       periodic_flag_q, alarm_match_flag_q};
                    default: begin
                        if (counter_byte(bus.addr)) begin
                            rdata_q <= user_copy_q[8*(bus.addr-ecc_pkg::ADDR_SEC0)
                                                   +ecc_pkg::SUBSEC_W +: 8];
                        end else begin
                            rdata_q <= 8'h00;
                        end
                    end
                endcase
            end
        end
    end

    assign bus.rdata  = rdata_q;
    assign bus.rd_ack = rd_ack_q;
endmodule

// file: ecc_host.sv
// host bridge: apb command registers drive the byte-wide device port
`timescale 1ns/10ps
module ecc_host (
    input  wire logic        core_clk,
    input  wire logic        reset,
    input  wire logic        psel,
    input  wire logic        penable,
    input  wire logic        pwrite,
    input  wire logic [31:0] paddr,
    input  wire logic [31:0] pwdata,
    output logic      [31:0] prdata,
    output logic             pready,
    output logic             pslverr,
    ecc_bus_if.host          bus
);
    typedef enum logic [2:0] {
        HB_IDLE = 3'b001,
        HB_READ = 3'b010,
        HB_WAIT = 3'b100
    } ecc_hb_state_e;

    ecc_hb_state_e state_q;
    logic [3:0]    addr_q;
    logic [7:0]    wdata_q;
    logic [7:0]    rdata_q;
    logic          wr_stb_q;
    logic          rd_stb_q;

    logic access;
    logic cmd_hit;
    logic stat_hit;
    assign access   = psel && penable;
    assign cmd_hit  = paddr == ecc_pkg::HB_CMD_OFFSET;
    assign stat_hit = paddr == ecc_pkg::HB_STAT_OFFSET;
    assign pready   = 1'b1;
    assign pslverr  = access && !cmd_hit && !stat_hit;

    logic busy;
    logic start;
    assign busy  = (state_q != HB_IDLE) || wr_stb_q;
    // a command written while busy is dropped
    assign start = access && pwrite && cmd_hit && !busy;

    // ------------------------------------------------------------
    // command sequencer
    // ------------------------------------------------------------
    // gate ordering for loads and reads is left to software
    always_ff @(posedge core_clk or posedge reset) begin
        if (reset) begin
            state_q  <= HB_IDLE;
            addr_q   <= 4'h0;
            wdata_q  <= 8'h00;
            wr_stb_q <= 1'b0;
            rd_stb_q <= 1'b0;
        end else begin
            wr_stb_q <= 1'b0;
            rd_stb_q <= 1'b0;
            case (state_q)
                HB_IDLE: begin
                    if (start) begin
                        addr_q  <= pwdata[ecc_pkg::HB_CMD_ADDR_LSB +: 4];
                        wdata_q <= pwdata[ecc_pkg::HB_CMD_WDATA_LSB +: 8];
                        if (pwdata[ecc_pkg::HB_CMD_WRITE_BIT]) begin
                            wr_stb_q <= 1'b1;
                        end else begin
                            rd_stb_q <= 1'b1;
                            state_q  <= HB_READ;
                        end
                    end
                end
                HB_READ: state_q <= HB_WAIT;
                HB_WAIT: begin
                    if (bus.rd_ack) begin
                        state_q <= HB_IDLE;
                    end
                end
                default: state_q <= HB_IDLE;
            endcase
        end
    end

    always_ff @(posedge core_clk or posedge reset) begin
        if (reset) begin
            rdata_q <= 8'h00;
        end else if (bus.rd_ack) begin
            rdata_q <= bus.rdata;
        end
    end

    always_comb begin
        prdata = 32'h0000_0000;
        if (stat_hit) begin
            prdata[ecc_pkg::HB_STAT_BUSY_BIT]       = busy;
            prdata[ecc_pkg::HB_STAT_RDATA_LSB +: 8] = rdata_q;
        end else if (cmd_hit) begin
            prdata[ecc_pkg::HB_CMD_ADDR_LSB +: 4]  = addr_q;
            prdata[ecc_pkg::HB_CMD_WDATA_LSB +: 8] = wdata_q;
        end
    end

    assign bus.addr   = addr_q;
    assign bus.wdata  = wdata_q;
    assign bus.wr_stb = wr_stb_q;
    assign bus.rd_stb = rd_stb_q;
endmodule

// file: ecc_pkg.sv
// shared constants of the elapsed counter control block and its host bridge
package ecc_pkg;
    // device byte register map
    localparam logic [3:0] ADDR_SUBSEC0 = 4'h0;
    localparam logic [3:0] ADDR_SUBSEC1 = 4'h1;
    localparam logic [3:0] ADDR_SEC0    = 4'h2;
    localparam logic [3:0] ADDR_SEC3    = 4'h5;
    localparam logic [3:0] ADDR_CTRL_A  = 4'ha;
    localparam logic [3:0] ADDR_CTRL_B  = 4'hb;
    localparam logic [3:0] ADDR_STATUS  = 4'hc;
    localparam logic [7:0] CTRL_A_RESET = 8'h00;
    localparam logic [7:0] CTRL_B_RESET = 8'h00;
    // control a fields
    localparam int CA_SHADOW_REFRESH_ALLOW = 7;
    localparam int CA_OSC_RUN_BIT          = 6;
    localparam int CA_COUNT_SOURCE_HI      = 5;
    localparam int CA_COUNT_SOURCE_LO      = 4;
    localparam int CA_EVENT_LEVEL_POLARITY = 3;
    localparam int CA_SQUARE_OUTPUT_ON     = 2;
    localparam int CA_PERIODIC_IRQ_MASK    = 1;
    localparam int CA_ALARM_IRQ_MASK       = 0;
    // control b fields
    localparam int CB_PERIODIC_RATE_LSB    = 4;
    localparam int CB_SQUARE_RATE_LSB      = 0;
    // status and subseconds0 fields
    localparam int ST_UPDATE_BUSY_FLAG     = 6;
    localparam int ST_PERIODIC_FLAG        = 1;
    localparam int ST_ALARM_MATCH_FLAG     = 0;
    localparam int SS0_SQUARE_HOLD_BIT     = 0;
    localparam int SS0_FRAC_LSB            = 4;
    // count source codes
    localparam logic [1:0] SRC_ALWAYS  = 2'h0;
    localparam logic [1:0] SRC_EVENT   = 2'h1;
    localparam logic [1:0] SRC_MAIN    = 2'h2;
    localparam logic [1:0] SRC_BATTERY = 2'h3;
    // counter geometry and prescalers
    localparam int COUNT_W       = 44;
    localparam int SUBSEC_W      = 12;
    localparam int TICK_DIV_W    = 3;   // 32768 / 8 = 4096 Hz
    localparam int SQ_PRESC_W    = 16;
    localparam int SQ_FREE_BITS  = 3;   // taps for 8192 and 4096 Hz never held
    // host bridge apb map
    localparam logic [31:0] HB_CMD_OFFSET  = 32'h0000_0000;
    localparam logic [31:0] HB_STAT_OFFSET = 32'h0000_0004;
    localparam int HB_CMD_ADDR_LSB  = 0;
    localparam int HB_CMD_WDATA_LSB = 8;
    localparam int HB_CMD_WRITE_BIT = 16;
    localparam int HB_STAT_BUSY_BIT = 0;
    localparam int HB_STAT_RDATA_LSB = 8;
endpackage

// file: ecc_props.sv
// concurrent checks on the byte port and the device control outputs
`timescale 1ns/10ps
module ecc_props (
    input wire logic       core_clk,
    input wire logic       reset,
    input wire logic [3:0] addr,
    input wire logic [7:0] wdata,
    input wire logic       wr_stb,
    input wire logic       rd_stb,
    input wire logic [7:0] rdata,
    input wire logic       rd_ack,
    input wire logic       osc_enable,
    input wire logic       irq_n_oe,
    input wire logic       square_wave_pin_o,
    input wire logic       square_wave_pin_oe,
    input wire logic       power_fail
);
    default clocking @(posedge core_clk); endclocking
    default disable iff (reset);
    // ----------------------------------------
    // shadow of the two control registers
    // ----------------------------------------
    logic [7:0] ca_q;
    logic [7:0] cb_q;
    always_ff @(posedge core_clk or posedge reset) begin
        if (reset) begin
            ca_q <= 8'h00;
            cb_q <= 8'h00;
        end else if (wr_stb && addr == 4'ha) begin
            ca_q <= wdata;
        end else if (wr_stb && addr == 4'hb) begin
            cb_q <= wdata;
        end
    end
    AST_RD_ACK: assert property (rd_stb |=> rd_ack)
        else $error("read strobe without ack");
    AST_ACK_CAUSE: assert property (rd_ack |-> $past(rd_stb))
        else $error("ack without read strobe");
    AST_ONE_STB: assert property (!(wr_stb && rd_stb))
        else $error("two strobes at once");
    AST_OSC: assert property (wr_stb && addr == 4'ha |=> osc_enable == $past(wdata[6]))
        else $error("oscillator enable does not follow control a");
    AST_SQ_LOW: assert property (!ca_q[2] && $past(!ca_q[2]) |-> !square_wave_pin_o)
        else $error("square pin not low while disabled");
    AST_SQ_OE: assert property (square_wave_pin_oe == !power_fail)
        else $error("square pin drive wrong for supply state");
    AST_IRQ_MASK: assert property (irq_n_oe |-> ca_q[1:0] != 2'h0)
        else $error("interrupt with both masks off");
    AST_IRQ_OFF: assert property (wr_stb && addr == 4'ha && wdata[1:0] == 2'h0 |=> !irq_n_oe)
        else $error("interrupt stays after masks cleared");
    AST_RD_A: assert property (rd_stb && addr == 4'ha |=> rdata == ca_q)
        else $error("control a readback wrong");
    AST_RD_B: assert property (rd_stb && addr == 4'hb |=> rdata == cb_q)
        else $error("control b readback wrong");
endmodule

// file: tb_elapsed_counter_control_periodic.sv
// self-checking bench: apb host bridge driving the counter device
`timescale 1ns/10ps
module tb_elapsed_counter_control_periodic;
    logic        core_clk, reset, psel, penable, pwrite, pready, pslverr, perr;
    logic [31:0] paddr, pwdata, prdata, q, r, seed;
    logic        osc_level = 1'b0, event_gate_input, on_battery, power_fail, alarm_match_set;
    logic        osc_enable, counting, irq_n_oe, square_wave_pin_o, square_wave_pin_oe;
    logic [1:0]  osc_div = 2'h0;
    logic [7:0]  v, w;
    logic        last;
    int          bad_count, total_checks, n, e, mreg[16];
    ecc_bus_if u_ecc_bus_if ();
    ecc_host u_ecc_host (.core_clk, .reset, .psel, .penable, .pwrite, .paddr, .pwdata,
        .prdata, .pready, .pslverr, .bus(u_ecc_bus_if));
    ecc_device u_ecc_device (.core_clk, .reset, .bus(u_ecc_bus_if), .osc_level,
        .event_gate_input, .on_battery, .power_fail, .alarm_match_set, .osc_enable,
        .counting, .irq_n_o(), .irq_n_oe, .square_wave_pin_o, .square_wave_pin_oe);
    ecc_props u_ecc_props (.core_clk, .reset, .addr(u_ecc_bus_if.addr),
        .wdata(u_ecc_bus_if.wdata), .wr_stb(u_ecc_bus_if.wr_stb), .rd_stb(u_ecc_bus_if.rd_stb),
        .rdata(u_ecc_bus_if.rdata), .rd_ack(u_ecc_bus_if.rd_ack), .osc_enable, .irq_n_oe,
        .square_wave_pin_o, .square_wave_pin_oe, .power_fail);
    // ----------------------------------------
    // clock, fast oscillator stand-in, helpers
    // ----------------------------------------
    initial begin
        core_clk = 1'b0;
        forever #4 core_clk = ~core_clk;
    end
    // oscillator sped up so ticks come every 32 core cycles
    always @(posedge core_clk) begin
        osc_div   <= osc_div + 2'h1;
        osc_level <= osc_div[1];
    end
    function logic [31:0] xs();
        seed = seed ^ (seed << 13);
        seed = seed ^ (seed >> 17);
        seed = seed ^ (seed << 5);
        return seed;
    endfunction
    task chk(input string nm, input logic [7:0] ex, input logic [7:0] got);
        total_checks++;
        if (got !== ex) begin
            bad_count++;
            $display("MISMATCH %s expected %h seen %h", nm, ex, got);
        end
    endtask
    task apb(input logic wr, input logic [31:0] a, input logic [31:0] d);
        psel    <= 1'b1;
        pwrite  <= wr;
        paddr   <= a;
        pwdata  <= d;
        @(posedge core_clk);
        penable <= 1'b1;
        do @(posedge core_clk); while (pready !== 1'b1);
        q       = prdata;
        perr    = pslverr;
        psel    <= 1'b0;
        penable <= 1'b0;
        @(posedge core_clk);
    endtask
    // one byte-port command, then poll busy; read byte lands in v
    task dev(input logic wr, input logic [3:0] a, input logic [7:0] d);
        apb(1'b1, 32'h0, {15'h0, wr, d, 4'h0, a});
        do apb(1'b0, 32'h4, 32'h0); while (q[0] !== 1'b0);
        v = q[15:8];
        if (wr) mreg[a] = d;
    endtask
    task tally_and_finish();
        if (bad_count == 0 && total_checks > 0) begin
            $display("Regression OK");
        end else begin
            $display("Regression broken");
        end
        $finish;
    endtask
    task wait_n(input int c);
        repeat (c) @(posedge core_clk);
    endtask
    initial begin
        #(8 * 60000);
        bad_count++;
        tally_and_finish();
    end
    // ----------------------------------------
    // scenarios
    // ----------------------------------------
    initial begin
        {reset, psel, penable, pwrite, paddr, pwdata} = {1'b1, 67'h0};
        {event_gate_input, on_battery, power_fail, alarm_match_set} = 4'h0;
        seed = 32'h2094c5b1;
        wait_n(10);
        reset <= 1'b0;
        @(posedge core_clk);
        dev(1'b0, 4'ha, 8'h00);
        chk("ctrl_a_rst", 8'h00, v);
        for (int i = 0; i < 4; i++) begin
            r = xs();
            dev(1'b1, 4'ha, r[7:0]);
            dev(1'b1, 4'hb, r[15:8]);
            dev(1'b0, 4'ha, 8'h00);
            chk("ctrl_a", 8'(mreg[10]), v);
            dev(1'b0, 4'hb, 8'h00);
            chk("ctrl_b", 8'(mreg[11]), v);
        end
        dev(1'b0, 4'h7, 8'h00);
        chk("hole_read", 8'h00, v);
        apb(1'b0, 32'h8, 32'h0);
        chk("apb_unmapped", 8'h01, 8'(perr));
        for (int i = 0; i < 16; i++) begin
            r = xs();
            dev(1'b1, 4'ha, {2'b01, r[1:0], r[2], 3'h0});
            event_gate_input <= r[3];
            on_battery       <= r[4];
            wait_n(2);
            e = (r[1:0] == 2'h0) || (r[1:0] == 2'h1 && r[3] == r[2]) ||
                (r[1:0] == 2'h2 && !r[4]) || (r[1:0] == 2'h3 && r[4]);
            chk("counting", 8'(e), 8'(counting));
        end
        on_battery <= 1'b0;
        dev(1'b1, 4'ha, 8'h42);
        dev(1'b1, 4'hb, 8'h00);
        dev(1'b1, 4'hc, 8'h00);
        wait_n(300);
        dev(1'b0, 4'hc, 8'h00);
        chk("pf_rate0", 8'h00, {7'h0, v[1]});
        dev(1'b1, 4'hb, 8'h10);
        wait_n(100);
        dev(1'b0, 4'hc, 8'h00);
        chk("pf_set", 8'h01, {7'h0, v[1]});
        chk("irq_pf", 8'h01, 8'(irq_n_oe));
        dev(1'b1, 4'hc, 8'h00);
        wait_n(100);
        dev(1'b0, 4'hc, 8'h00);
        chk("pf_again", 8'h01, {7'h0, v[1]});
        dev(1'b1, 4'ha, 8'h40);
        chk("irq_masked", 8'h00, 8'(irq_n_oe));
        dev(1'b1, 4'ha, 8'h01);
        dev(1'b1, 4'hc, 8'h00);
        dev(1'b0, 4'hc, 8'h00);
        chk("pf_clear", 8'h00, {7'h0, v[1]});
        alarm_match_set <= 1'b1;
        @(posedge core_clk);
        alarm_match_set <= 1'b0;
        wait_n(2);
        chk("irq_alarm", 8'h01, 8'(irq_n_oe));
        dev(1'b1, 4'hb, 8'h03);
        dev(1'b1, 4'h0, 8'h01);
        dev(1'b1, 4'ha, 8'h44);
        for (int k = 0; k < 2; k++) begin
            n = 0;
            last = square_wave_pin_o;
            repeat (120) begin
                @(posedge core_clk);
                n += (square_wave_pin_o !== last);
                last = square_wave_pin_o;
            end
            chk("sq_toggles", 8'(k), 8'(n != 0));
            dev(1'b1, 4'h0, 8'h00);
        end
        power_fail <= 1'b1;
        wait_n(2);
        chk("sq_oe_pf", 8'h00, 8'(square_wave_pin_oe));
        power_fail <= 1'b0;
        do dev(1'b0, 4'hc, 8'h00); while (v[6] !== 1'b0);
        dev(1'b1, 4'ha, 8'h40);
        dev(1'b0, 4'h1, 8'h00);
        w = v;
        wait_n(1200);
        dev(1'b0, 4'h1, 8'h00);
        chk("copy_frozen", w, v);
        dev(1'b1, 4'ha, 8'hc0);
        wait_n(1200);
        dev(1'b0, 4'h1, 8'h00);
        chk("copy_refresh", 8'h01, 8'(v != w));
        tally_and_finish();
    end
endmodule
